// >>> core/caccu_defines.svh
`ifndef CACCU_DEFINES_SVH
`define CACCU_DEFINES_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define CACCU_IDX_COUNTER_MODE 10'h0d9
`define CACCU_IDX_CONTROL 10'h0d8
`define CACCU_IDX_IRQ_STATUS 10'h0d0
`define CACCU_IDX_IRQ_MASK 10'h0d1
`define CACCU_IDX_MODE_BASE 10'h0da
`define CACCU_IDX_CMP_LO_BASE 10'h0e0
`define CACCU_IDX_CMP_HI_BASE 10'h0f0
`define CACCU_IDX_CNT_LO 10'h0e8
`define CACCU_IDX_CNT_HI 10'h0f8

// ****************************************
// Counter mode register fields
// ****************************************
`define CACCU_CM_IDLE_GATE 7
`define CACCU_CM_WDT_ON 6
`define CACCU_CM_SRC_HI 2
`define CACCU_CM_SRC_LO 1
`define CACCU_CM_OVF_IRQ 0
`define CACCU_CM_IMPL_MASK 8'hc7

// ****************************************
// Control register fields
// ****************************************
`define CACCU_CT_OVF_FLAG 7
`define CACCU_CT_RUN 6

// ****************************************
// Module mode register fields
// ****************************************
`define CACCU_MM_COMPARE_EN 6
`define CACCU_MM_MATCH_EN 3
`define CACCU_MM_TOGGLE_EN 2
`define CACCU_MM_IRQ_EN 0

// ****************************************
// Reset values, prescale counts and response codes
// ****************************************
`define CACCU_RST_BYTE 8'h00
`define CACCU_DIV_SLOW 4'hc
`define CACCU_DIV_SLOW_X2 4'h6
`define CACCU_DIV_FAST 4'h4
`define CACCU_DIV_FAST_X2 4'h2
`define CACCU_RESP_OKAY 2'h0
`define CACCU_RESP_SLVERR 2'h2

`endif

// >>> core/caccu_pkg.sv
package caccu_pkg;
  // Count source encodings
  typedef enum logic [1:0] {
    CACCU_SRC_SLOW = 2'b00,
    CACCU_SRC_FAST = 2'b01,
    CACCU_SRC_T0OVF = 2'b10,
    CACCU_SRC_EXT = 2'b11
  } caccu_src_t;
endpackage : caccu_pkg

// >>> core/caccu_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Idle gate bit 0 keeps counting in idle; 1 stops counting while idle.
// - Watchdog bit enables the watchdog action of compare module four.
// - Two-bit source picks osc/12(/6), osc/4(/2), timer0 overflow, or external pin.
// - Overflow flag requests an interrupt only while overflow interrupt enable is set; here the enable only gates setting a sticky status bit.
// - Compare enable plus match enable make a module a 16-bit compare timer.
// - A match interrupts only when match flag and module interrupt enable are set; here the enable only gates setting a sticky status bit.
// - Writing the compare high byte sets compare enable.
// - Writing the compare low byte while compare enabled clears compare enable.
// - In toggle mode the module output pin inverts on every match.
// - Toggle mode needs toggle, match and compare enable all set.
// - Compare enable stays directly readable and writable in the mode register.
// - Reserved counter mode bits read undefined; software writes zeros there.
`include "caccu_defines.svh"

module caccu_top #(
  parameter int NUM_MOD = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core_idle,
  input wire logic clock_doubling,
  input wire logic timer0_overflow,
  input wire logic external_count_pin,
  output logic [NUM_MOD-1:0] module_output_pin,
  output logic watchdog_reset,
  output logic irq
);
  import caccu_pkg::*;

  // Module four must exist for the watchdog action
  // Match flags share the control byte with run and overflow, so six modules at most
  if (NUM_MOD < 5 || NUM_MOD > 6) begin : g_bad_num_mod
    $error("caccu_top: NUM_MOD must lie between 5 and 6");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Register bus side
    logic aw_hold;
    logic [9:0] aw_idx;
    logic w_hold;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // Counter mode, run and flags
    logic [7:0] array_counter_mode;
    logic run;
    logic ovf_flag;
    logic [NUM_MOD-1:0] match_flag;
    // Per-module mode and compare bytes
    logic [NUM_MOD-1:0][7:0] mode;
    logic [NUM_MOD-1:0][7:0] cmp_lo;
    logic [NUM_MOD-1:0][7:0] cmp_hi;
    // Shared counter, prescaler and pin synchroniser
    logic [15:0] cnt;
    logic [3:0] pre;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    // Module outputs and interrupt status
    logic [NUM_MOD-1:0] pin;
    logic wdt_rst;
    logic [NUM_MOD:0] irq_stat;
    logic [NUM_MOD:0] irq_mask;
  } caccu_state_t;

  caccu_state_t s_r;
  caccu_state_t s_nxt;

  // ****************************************
  // Address decode helpers
  // ****************************************
  // Returns 1 when idx lies in the per-module window starting at base
  function automatic logic in_bank(input logic [9:0] idx, input logic [9:0] base);
    in_bank = (idx >= base) && (idx < base + 10'(NUM_MOD));
  endfunction : in_bank

  // Returns 1 for every index that maps to a register
  function automatic logic is_mapped(input logic [9:0] idx);
    is_mapped = (idx == `CACCU_IDX_COUNTER_MODE) || (idx == `CACCU_IDX_CONTROL) ||
      (idx == `CACCU_IDX_IRQ_STATUS) || (idx == `CACCU_IDX_IRQ_MASK) ||
      (idx == `CACCU_IDX_CNT_LO) || (idx == `CACCU_IDX_CNT_HI) ||
      in_bank(idx, `CACCU_IDX_MODE_BASE) || in_bank(idx, `CACCU_IDX_CMP_LO_BASE) ||
      in_bank(idx, `CACCU_IDX_CMP_HI_BASE);
  endfunction : is_mapped

  // Returns 1 when idx addresses module m of the bank starting at base
  function automatic logic mod_hit(input logic [9:0] idx, input logic [9:0] base, input int m);
    mod_hit = (idx == base + 10'(m));
  endfunction : mod_hit

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic do_wr;
    logic do_rd;
    logic [9:0] ridx;
    logic [7:0] wd;
    logic [7:0] rv;
    logic [3:0] div;
    logic tick;
    logic [15:0] cnt_inc;
    logic ovf_ev;
    logic [NUM_MOD-1:0] match_ev;
    caccu_src_t src;
    do_wr = 1'b0;
    do_rd = 1'b0;
    ridx = s_axi_araddr[11:2];
    wd = s_r.w_data;
    rv = `CACCU_RST_BYTE;
    div = `CACCU_DIV_SLOW;
    tick = 1'b0;
    cnt_inc = s_r.cnt + 16'h0001;
    ovf_ev = 1'b0;
    match_ev = '0;
    src = caccu_src_t'({s_r.array_counter_mode[`CACCU_CM_SRC_HI], s_r.array_counter_mode[`CACCU_CM_SRC_LO]});
    s_nxt = s_r;
    s_nxt.wdt_rst = 1'b0;

    // Pin synchroniser; the second and third stages feed the edge detector
    s_nxt.ext_s1 = external_count_pin;
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_s3 = s_r.ext_s2;

    // Write channels are caught independently and joined here
    if (s_axi_awvalid && !s_r.aw_hold) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && !s_r.w_hold) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.w_data = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // A response still waiting holds the next write off
    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      do_wr = s_r.w_lane0 && is_mapped(s_r.aw_idx);
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = is_mapped(s_r.aw_idx) ? `CACCU_RESP_OKAY : `CACCU_RESP_SLVERR;
    end

    // Register writes; hardware sets below take priority over clears
    if (do_wr) begin
      case (s_r.aw_idx)
        `CACCU_IDX_COUNTER_MODE: s_nxt.array_counter_mode = wd & `CACCU_CM_IMPL_MASK;
        `CACCU_IDX_CONTROL: begin
          s_nxt.run = wd[`CACCU_CT_RUN];
          if (wd[`CACCU_CT_OVF_FLAG]) begin
            s_nxt.ovf_flag = 1'b0;
          end
          s_nxt.match_flag = s_r.match_flag & ~wd[NUM_MOD-1:0];
        end
        `CACCU_IDX_IRQ_STATUS: s_nxt.irq_stat = s_r.irq_stat & ~wd[NUM_MOD:0];
        `CACCU_IDX_IRQ_MASK: s_nxt.irq_mask = wd[NUM_MOD:0];
        `CACCU_IDX_CNT_LO: s_nxt.cnt[7:0] = wd;
        `CACCU_IDX_CNT_HI: s_nxt.cnt[15:8] = wd;
        default: begin
          for (int m = 0; m < NUM_MOD; m++) begin
            if (mod_hit(s_r.aw_idx, `CACCU_IDX_MODE_BASE, m)) begin
              s_nxt.mode[m] = wd;
            end
            if (mod_hit(s_r.aw_idx, `CACCU_IDX_CMP_HI_BASE, m)) begin
              s_nxt.cmp_hi[m] = wd;
              s_nxt.mode[m][`CACCU_MM_COMPARE_EN] = 1'b1;
            end
            if (mod_hit(s_r.aw_idx, `CACCU_IDX_CMP_LO_BASE, m)) begin
              s_nxt.cmp_lo[m] = wd;
              if (s_r.mode[m][`CACCU_MM_COMPARE_EN]) begin
                s_nxt.mode[m][`CACCU_MM_COMPARE_EN] = 1'b0;
              end
            end
          end
        end
      endcase
    end

    // Count source selection
    case (src)
      CACCU_SRC_SLOW: div = clock_doubling ? `CACCU_DIV_SLOW_X2 : `CACCU_DIV_SLOW;
      CACCU_SRC_FAST: div = clock_doubling ? `CACCU_DIV_FAST_X2 : `CACCU_DIV_FAST;
      default: div = `CACCU_DIV_SLOW;
    endcase

    // Prescaler runs free, so the first count after start may come early
    if (s_r.pre >= div - 4'h1) begin
      s_nxt.pre = 4'h0;
    end else begin
      s_nxt.pre = s_r.pre + 4'h1;
    end
    // One count per tick; the pin count uses the synchronised copy only
    case (src)
      CACCU_SRC_SLOW: tick = (s_r.pre >= div - 4'h1);
      CACCU_SRC_FAST: tick = (s_r.pre >= div - 4'h1);
      CACCU_SRC_T0OVF: tick = timer0_overflow;
      CACCU_SRC_EXT: tick = s_r.ext_s3 && !s_r.ext_s2;
      default: tick = 1'b0;
    endcase
    // Idle gating stops increments only, so registers stay reachable
    tick = tick && s_r.run && !(core_idle && s_r.array_counter_mode[`CACCU_CM_IDLE_GATE]);

    // Shared counter and per-module compare
    if (tick) begin
      s_nxt.cnt = cnt_inc;
      ovf_ev = (s_r.cnt == 16'hffff);
      for (int m = 0; m < NUM_MOD; m++) begin
        match_ev[m] = s_r.mode[m][`CACCU_MM_COMPARE_EN] && s_r.mode[m][`CACCU_MM_MATCH_EN] &&
          (cnt_inc == {s_r.cmp_hi[m], s_r.cmp_lo[m]});
      end
    end

    // Overflow always sets its flag, the status bit only while enabled
    if (ovf_ev) begin
      s_nxt.ovf_flag = 1'b1;
      if (s_r.array_counter_mode[`CACCU_CM_OVF_IRQ]) begin
        s_nxt.irq_stat[0] = 1'b1;
      end
    end
    // Per-module effects of a match land on the same edge as the count
    for (int m = 0; m < NUM_MOD; m++) begin
      if (match_ev[m]) begin
        s_nxt.match_flag[m] = 1'b1;
        if (s_r.mode[m][`CACCU_MM_IRQ_EN]) begin
          s_nxt.irq_stat[m+1] = 1'b1;
        end
        if (s_r.mode[m][`CACCU_MM_TOGGLE_EN]) begin
          s_nxt.pin[m] = ~s_r.pin[m];
        end
      end
    end

    // Watchdog action of module four
    if (match_ev[4] && s_r.array_counter_mode[`CACCU_CM_WDT_ON]) begin
      s_nxt.wdt_rst = 1'b1;
    end

    // Read channel: one read at a time, data registered
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    do_rd = s_axi_arvalid && !s_r.rvalid;
    // Read mux; unmapped indices read zero
    case (ridx)
      `CACCU_IDX_COUNTER_MODE: rv = s_r.array_counter_mode;
      `CACCU_IDX_CONTROL: begin
        rv[`CACCU_CT_OVF_FLAG] = s_r.ovf_flag;
        rv[`CACCU_CT_RUN] = s_r.run;
        rv[NUM_MOD-1:0] = s_r.match_flag;
      end
      `CACCU_IDX_IRQ_STATUS: rv[NUM_MOD:0] = s_r.irq_stat;
      `CACCU_IDX_IRQ_MASK: rv[NUM_MOD:0] = s_r.irq_mask;
      `CACCU_IDX_CNT_LO: rv = s_r.cnt[7:0];
      `CACCU_IDX_CNT_HI: rv = s_r.cnt[15:8];
      default: begin
        for (int m = 0; m < NUM_MOD; m++) begin
          if (mod_hit(ridx, `CACCU_IDX_MODE_BASE, m)) begin
            rv = s_r.mode[m];
          end
          if (mod_hit(ridx, `CACCU_IDX_CMP_LO_BASE, m)) begin
            rv = s_r.cmp_lo[m];
          end
          if (mod_hit(ridx, `CACCU_IDX_CMP_HI_BASE, m)) begin
            rv = s_r.cmp_hi[m];
          end
        end
      end
    endcase
    // Data is registered so it stands unchanged while rvalid waits
    if (do_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rv;
      s_nxt.rresp = is_mapped(ridx) ? `CACCU_RESP_OKAY : `CACCU_RESP_SLVERR;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset clears every field; every reset value is zero
  // Reset acts on a clock edge only, so the clock must run during reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Ready terms are combinational so a channel is taken in the same cycle
  assign s_axi_awready = !s_r.aw_hold;
  assign s_axi_wready = !s_r.w_hold;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  // Read channel outputs
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = {24'h000000, s_r.rdata};
  assign s_axi_rresp = s_r.rresp;

  // Pins, watchdog pulse and interrupt level
  assign module_output_pin = s_r.pin;
  assign watchdog_reset = s_r.wdt_rst;
  assign irq = |(s_r.irq_stat & s_r.irq_mask);
endmodule : caccu_top

// >>> bench/caccu_properties.sv
`timescale 1ns/1ps
// ****************************************
// Port-level checks
// ****************************************
module caccu_properties #(
  parameter int NUM_MOD = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_MOD-1:0] module_output_pin,
  input wire logic watchdog_reset,
  input wire logic irq
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshake steps of the register bus
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read accepted while busy");
  property p_rd_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("upper read bits not zero");
  // A match lasts one count, so pin 0 cannot flip twice in a row
  property p_pin_once; $changed(module_output_pin[0]) |=> $stable(module_output_pin[0]); endproperty
  a_pin_once: assert property (p_pin_once) else $error("output pin toggled twice");
  property p_wdog_pulse; watchdog_reset |=> !watchdog_reset; endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog pulse too long");
  // Flags are sticky: the request only drops when software writes
  property p_irq_sticky; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped alone");
endmodule : caccu_properties

bind caccu_top caccu_properties #(.NUM_MOD(NUM_MOD)) i_caccu_properties (.*);

// >>> bench/counter_array_compare_unit_tb_top.sv
`timescale 1ns/1ps
`include "caccu_defines.svh"
module counter_array_compare_unit_tb_top;
  import caccu_pkg::*;
  localparam logic [9:0] I_CM = `CACCU_IDX_COUNTER_MODE;
  localparam logic [9:0] I_CT = `CACCU_IDX_CONTROL;
  localparam logic [9:0] I_ST = `CACCU_IDX_IRQ_STATUS;
  localparam logic [9:0] I_MK = `CACCU_IDX_IRQ_MASK;
  localparam logic [9:0] I_MD = `CACCU_IDX_MODE_BASE;
  localparam logic [9:0] I_LO = `CACCU_IDX_CMP_LO_BASE;
  localparam logic [9:0] I_HI = `CACCU_IDX_CMP_HI_BASE;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic idle = 1'b0, dbl = 1'b0, t0ovf = 1'b0, extp = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, wdog, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rv;
  logic [4:0] pins;
  int failures = 0, checks_done = 0, wd_cnt = 0;
  // ****************************************
  // Clock, watchdog pulse count, design
  // ****************************************
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    if (wdog === 1'b1) wd_cnt <= wd_cnt + 1;
  end
  caccu_top i_caccu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_idle(idle),
    .clock_doubling(dbl), .timer0_overflow(t0ovf), .external_count_pin(extp),
    .module_output_pin(pins), .watchdog_reset(wdog), .irq(irq));
  task automatic finish_test();
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic hang();
    failures++;
    finish_test();
  endtask : hang
  // Bus tasks hold each valid until its own ready, then wait for the answer
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (bvalid === 1'b1 && bready === 1'b1) break;
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
      // Accept the answer one cycle late so the hold checks see a wait
      bready <= (bvalid === 1'b1);
    end
    bready <= 1'b0;
    if (n == 40) hang();
    check({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [1:0] er = 2'h0);
    int n;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (rvalid === 1'b1 && rready === 1'b1) break;
      arvalid <= arvalid && !arready;
      rready <= (rvalid === 1'b1);
    end
    rready <= 1'b0;
    if (n == 40) hang();
    rv = rdata;
    check({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    rd(idx);
    check(rv, {24'h0, e});
  endtask : rdc
  task automatic pulse(input int n);
    repeat (n) begin
      t0ovf <= 1'b1;
      @(posedge aclk);
      t0ovf <= 1'b0;
      @(posedge aclk);
    end
  endtask : pulse
  // Stop, clear all control flags, preset the shared counter
  task automatic load(input logic [15:0] v);
    wr(I_CT, 8'h9f);
    wr(`CACCU_IDX_CNT_LO, v[7:0]);
    wr(`CACCU_IDX_CNT_HI, v[15:8]);
  endtask : load
  // Count for a fixed window; bus latency adds up to three counts
  task automatic rate(input logic [7:0] cm, input logic d, input logic i, input int e);
    int k;
    wr(I_CM, cm);
    dbl <= d;
    idle <= i;
    load(16'h0000);
    wr(I_CT, 8'h40);
    for (k = 0; k < 96; k++) begin
      t0ovf <= (k % 3 == 0);
      if (k % 8 == 0) extp <= ~extp;
      @(posedge aclk);
    end
    t0ovf <= 1'b0;
    wr(I_CT, 8'h00);
    rd(`CACCU_IDX_CNT_LO);
    check(32'(rv + 1 >= e && rv <= e + 3), 32'h1);
  endtask : rate
  task automatic t_regs();
    rdc(I_CM, 8'h00);
    wr(I_CM, 8'hc7);
    rdc(I_CM, 8'hc7);
    wr(10'h3ff, 8'h01, 2'h2);
    rd(10'h3ff, 2'h2);
  endtask : t_regs
  task automatic t_auto();
    wr(I_MD + 10'd1, 8'h08);
    wr(I_LO + 10'd1, 8'h34);
    rdc(I_MD + 10'd1, 8'h08);
    wr(I_HI + 10'd1, 8'h12);
    rdc(I_MD + 10'd1, 8'h48);
    wr(I_LO + 10'd1, 8'h35);
    rdc(I_MD + 10'd1, 8'h08);
    wr(I_MD + 10'd1, 8'h48);
    rdc(I_MD + 10'd1, 8'h48);
    wr(I_MD + 10'd1, 8'h00);
  endtask : t_auto
  task automatic t_match();
    load(16'h0000);
    wr(I_LO, 8'h05);
    wr(I_HI, 8'h00);
    wr(I_MD, 8'h4d);
    wr(I_MK, 8'h00);
    wr(I_CM, 8'h04);
    wr(I_CT, 8'h40);
    pulse(5);
    check(32'(pins), 32'h1);
    rdc(I_CT, 8'h41);
    check(32'(irq), 32'h0);
    wr(I_MK, 8'h02);
    check(32'(irq), 32'h1);
    pulse(1);
    check(32'(pins), 32'h1);
    wr(I_ST, 8'h02);
    check(32'(irq), 32'h0);
    load(16'h0000);
    wr(I_MD, 8'h48);
    wr(I_CT, 8'h40);
    pulse(5);
    check(32'(pins), 32'h1);
    rdc(I_CT, 8'h41);
  endtask : t_match
  task automatic t_wdog();
    for (int w = 0; w < 2; w++) begin
      load(16'h0000);
      wr(I_LO + 10'd4, 8'h03);
      wr(I_HI + 10'd4, 8'h00);
      wr(I_MD + 10'd4, 8'h48);
      wr(I_CM, w == 1 ? 8'h44 : 8'h04);
      wr(I_CT, 8'h40);
      pulse(3);
      // The pulse counter settles one edge after the pulse is seen
      @(posedge aclk);
      check(32'(wd_cnt), 32'(w));
    end
  endtask : t_wdog
  task automatic t_ovf();
    load(16'hffff);
    wr(I_MK, 8'h01);
    wr(I_CM, 8'h04);
    wr(I_CT, 8'h40);
    pulse(1);
    check(32'(irq), 32'h0);
    load(16'hffff);
    wr(I_CM, 8'h05);
    wr(I_ST, 8'h01);
    wr(I_CT, 8'h40);
    pulse(1);
    check(32'(irq), 32'h1);
    rdc(I_CT, 8'hc0);
    wr(I_ST, 8'h01);
    check(32'(irq), 32'h0);
  endtask : t_ovf
  // Main sequence after three reset cycles
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_auto();
    rate(8'h82, 0, 1, 0);
    rate(8'h02, 0, 1, 24);
    rate(8'h00, 0, 0, 8);
    rate(8'h00, 1, 0, 16);
    rate(8'h02, 1, 0, 48);
    rate(8'h04, 0, 0, 32);
    rate(8'h06, 0, 0, 6);
    t_match();
    t_wdog();
    t_ovf();
    finish_test();
  end
  // Overall limit against a hang anywhere
  initial begin
    repeat (60000) @(posedge aclk);
    hang();
  end
endmodule : counter_array_compare_unit_tb_top
